// ==== pkg/rst_wdt_pkg.sv ====
// Constants, register map and shared types of the reset and watchdog block.
`default_nettype none
package rst_wdt_pkg;
   // ------------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------------
   localparam int CLK_MHZ = 125;
   localparam int POR_DELAY_MS = 100;
   localparam int POR_DELAY_CYC = POR_DELAY_MS * 1000 * CLK_MHZ;
   localparam int MCD_TIMEOUT_US = 220;
   localparam int MCD_TIMEOUT_CYC = MCD_TIMEOUT_US * CLK_MHZ;
   localparam int PIN_STRETCH_CYC = 12;
   localparam int DLY_W = 24;
   localparam int WD_CNT_W = 21;
   localparam logic [4:0] WD_EXP_BASE = 5'h06;
   localparam logic [2:0] WD_DIS_WINDOW = 3'h4;
   // ------------------------------------------------------------------
   // Register map (index; byte address is four times the index)
   // ------------------------------------------------------------------
   localparam int ADDR_W = 10;
   localparam logic [7:0] RESET_CAUSE_IDX = 8'hEF;
   localparam logic [7:0] WDOG_CTRL_IDX = 8'hFF;
   localparam logic [7:0] IRQ_STATUS_IDX = 8'hE0;
   localparam logic [7:0] IRQ_MASK_IDX = 8'hE1;
   localparam logic [6:0] RESET_CAUSE_RST = 7'h00;
   localparam logic [6:0] CAUSE_POR_ONLY = 7'h02;
   localparam logic [2:0] WD_INTERVAL_RST = 3'h7;
   localparam int WD_STATUS_BIT = 4;
   localparam int WD_INTVL_SEL_BIT = 7;
   localparam logic [7:0] WD_ENABLE_CODE = 8'hA5;
   localparam logic [7:0] WD_DIS1_CODE = 8'hDE;
   localparam logic [7:0] WD_DIS2_CODE = 8'hAD;
   localparam logic [7:0] WD_LOCK_CODE = 8'hFF;
   localparam int CNV_BIT = 6;
   localparam int CMP_BIT = 5;
   localparam int SW_BIT = 4;
   localparam int MCD_BIT = 2;
   localparam int POR_BIT = 1;
   localparam int PIN_BIT = 0;
   localparam int IRQ_W = 3;
   localparam int EV_WD_OFF = 0;
   localparam int EV_DIS_REFUSED = 1;
   localparam int EV_LOCK = 2;
   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic cnv;
      logic cmp;
      logic sw;
      logic wdt;
      logic missing_clock_detector;
      logic por;
      logic pin;
   } cause_t;
   typedef enum logic [1:0] {ST_RUN, ST_POR, ST_PIN, ST_STRETCH} seq_state_t;
endpackage
`default_nettype wire

// ==== design/input_sync.sv ====
// Two-flop synchroniser for asynchronous input pins.
`default_nettype none
module input_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   if (WIDTH < 1) begin : g_chk
      $error("input_sync: WIDTH must be at least 1");
   end
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_r;
      logic sync_r;
      // The reset-source inputs are active low, so the idle level after reset is one.
      always_ff @(posedge clk_sys) begin
         if (!rst_n) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
         end else if (ce) begin
            meta_r <= din[i];
            sync_r <= meta_r;
         end
      end
      assign dout[i] = sync_r;
   end
endmodule // input_sync
`default_nettype wire

// ==== design/watchdog_timer.sv ====
// Watchdog counter with enable, timed disable sequence, lockout and interval.
`default_nettype none
module watchdog_timer
   import rst_wdt_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic clear,
   input wire logic wr,
   input wire logic [7:0] wdata,
   output logic active,
   output logic [2:0] interval,
   output logic timeout,
   output logic [IRQ_W-1:0] events
);
   logic active_r;
   logic lock_r;
   logic [2:0] intvl_r;
   logic [2:0] win_r;
   logic [WD_CNT_W-1:0] cnt_r;
   logic [WD_CNT_W-1:0] limit;
   logic [4:0] shamt;
   logic do_en;
   logic do_dis1;
   logic do_dis2;
   logic do_lock;
   logic do_intvl;
   logic dis_ok;

   assign do_en = wr && (wdata == WD_ENABLE_CODE);
   assign do_dis1 = wr && (wdata == WD_DIS1_CODE);
   assign do_dis2 = wr && (wdata == WD_DIS2_CODE);
   assign do_lock = wr && (wdata == WD_LOCK_CODE);
   assign do_intvl = wr && !wdata[WD_INTVL_SEL_BIT];
   assign dis_ok = do_dis2 && (win_r != 3'h0) && !lock_r;
   // Timeout is 4^(3+n) clocks, that is 2^(6+2n).
   assign shamt = WD_EXP_BASE + {1'b0, intvl_r, 1'b0};
   assign limit = WD_CNT_W'(1) << shamt;
   // Compare with >= so that shortening the interval mid-count still expires.
   assign timeout = active_r && (cnt_r >= limit - WD_CNT_W'(1));
   assign events[EV_WD_OFF] = dis_ok;
   assign events[EV_DIS_REFUSED] = do_dis2 && !dis_ok;
   assign events[EV_LOCK] = do_lock;
   assign active = active_r;
   assign interval = intvl_r;

   always_ff @(posedge clk_sys) begin
      if (!rst_n || clear) begin
         active_r <= 1'b1;
         lock_r <= 1'b0;
         intvl_r <= WD_INTERVAL_RST;
         win_r <= 3'h0;
         cnt_r <= '0;
      end else if (ce) begin
         if (do_en || timeout) begin
            cnt_r <= '0;
         end else if (active_r) begin
            cnt_r <= cnt_r + WD_CNT_W'(1);
         end
         if (do_en) begin
            active_r <= 1'b1;
         end else if (dis_ok) begin
            active_r <= 1'b0;
         end
         if (do_lock) begin
            lock_r <= 1'b1;
         end
         if (do_dis1) begin
            win_r <= WD_DIS_WINDOW;
         end else if (win_r != 3'h0) begin
            win_r <= win_r - 3'h1;
         end
         if (do_intvl) begin
            intvl_r <= wdata[2:0];
         end
      end
   end

   property p_wd_en;
      @(posedge clk_sys) disable iff (!rst_n || !ce)
      do_en && !clear |=> active_r && (cnt_r == '0);
   endproperty
   a_wd_en: assert property (p_wd_en)
      else $error("Enable code did not start the watchdog from zero.");

   property p_wd_dis;
      @(posedge clk_sys) disable iff (!rst_n || !ce || clear)
      do_dis1 ##[1:4] (do_dis2 && !lock_r) |=> !active_r;
   endproperty
   a_wd_dis: assert property (p_wd_dis)
      else $error("Timely disable sequence did not stop the watchdog.");

   property p_wd_lock;
      @(posedge clk_sys) disable iff (!rst_n || !ce || clear)
      lock_r && do_dis2 && !do_en |=> active_r == $past(active_r);
   endproperty
   a_wd_lock: assert property (p_wd_lock)
      else $error("Locked watchdog changed state on a disable attempt.");

   property p_wd_intvl;
      @(posedge clk_sys) disable iff (!rst_n || !ce)
      clear |=> intvl_r == WD_INTERVAL_RST;
   endproperty
   a_wd_intvl: assert property (p_wd_intvl)
      else $error("Interval is not at its longest after reset.");
endmodule // watchdog_timer
`default_nettype wire

// ==== design/reset_source_and_watchdog_ctrl.sv ====
// Reset-cause capture, reset sequencing and watchdog control registers.
// ---------------------------------------------------------------------
// Summary of operation
// - Enable code starts the watchdog and clears its count.
// - Two disable codes within four clocks stop the watchdog; else ignored.
// - Lock code blocks disabling until reset; it neither enables nor reloads.
// - Watchdog control bit 4 reads the watchdog running state.
// - Low three control bits set the interval, reset to 111; bit 7 zero.
// - Cause bit 6 enables convert-start low as source; reads its cause.
// - Cause bit 5 enables comparator low as source; reads its cause.
// - Cause bit 4 forces internal reset, pin untouched; reads software cause.
// - Cause bit 3 reads one after a watchdog timeout reset.
// - Cause bit 2 enables missing clock detector; reads its cause.
// - Detector resets when core clock is absent for its timeout window.
// - With monitor pin high, bit 1 selects supply monitor as source.
// - Bit 1 reads one after power-on; other cause bits then meaningless.
// - Writing cause bit 0 forces power-on reset and drives the pin low.
// - Cause bit 0 reads one after an external pin reset.
// - Watchdog timeout is four to the power three plus interval clocks.
// - Stay in reset twelve clocks after the reset pin releases.
// ---------------------------------------------------------------------
`default_nettype none
module reset_source_and_watchdog_ctrl
   import rst_wdt_pkg::*;
#(
   parameter int POR_DELAY = POR_DELAY_CYC,
   parameter int MCD_TIMEOUT = MCD_TIMEOUT_CYC
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic irq,
   input wire logic convert_start_input,
   input wire logic comparator_out,
   input wire logic supply_monitor_enable_pin,
   input wire logic supply_ok_in,
   input wire logic reset_pin_in,
   input wire logic core_clk_activity,
   output logic reset_pin_out,
   output logic reset_pin_oe,
   output logic sys_rst_n_out
);
   // ------------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------------
   if (POR_DELAY < 1 || POR_DELAY >= 2 ** DLY_W) begin : g_chk_por
      $error("POR_DELAY out of range for the delay counter");
   end
   if (MCD_TIMEOUT < 1 || MCD_TIMEOUT >= 2 ** DLY_W) begin : g_chk_mcd
      $error("MCD_TIMEOUT out of range for the detector counter");
   end

   localparam logic [DLY_W-1:0] POR_LAST = DLY_W'(POR_DELAY - 1);
   localparam logic [DLY_W-1:0] MCD_LAST = DLY_W'(MCD_TIMEOUT - 1);
   localparam logic [DLY_W-1:0] STRETCH_LAST = DLY_W'(PIN_STRETCH_CYC - 1);

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   logic [5:0] pins_raw;
   logic [5:0] pins_s;
   logic cnv_s, cmp_s, mon_s, sup_s, pin_s, act_s;
   logic act_q_r;
   logic sel_cause, sel_wd, sel_stat, sel_mask;
   logic run;
   logic wr_cause, wr_wd;
   logic por_trig, por_force, pin_trig, sw_trig, mcd_trig, cnv_trig, cmp_trig;
   logic wd_active;
   logic [2:0] wd_intvl;
   logic wd_timeout;
   logic [IRQ_W-1:0] wd_events;
   seq_state_t state_r, state_nxt;
   cause_t pend_r, pend_nxt, cause_r;
   logic [DLY_W-1:0] dly_r, dly_nxt, mcd_cnt_r;
   logic cnv_en_r, cmp_en_r, mcd_en_r, por_sel_r;
   logic [IRQ_W-1:0] stat_r, stat_nxt, mask_r;
   logic [7:0] rd_val, rdata_r;
   logic irq_r, rst_pin_oe_r, sys_rst_n_r;

   // ------------------------------------------------------------------
   // Pin synchronisation
   // ------------------------------------------------------------------
   assign pins_raw = {core_clk_activity, reset_pin_in, supply_ok_in,
                      supply_monitor_enable_pin, comparator_out,
                      convert_start_input};

   input_sync #(
      .WIDTH(6)
   ) u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .ce(ce),
      .din(pins_raw),
      .dout(pins_s)
   );

   assign cnv_s = pins_s[0];
   assign cmp_s = pins_s[1];
   assign mon_s = pins_s[2];
   assign sup_s = pins_s[3];
   assign pin_s = pins_s[4];
   assign act_s = pins_s[5];

   // ------------------------------------------------------------------
   // Register decode
   // ------------------------------------------------------------------
   assign sel_cause = (reg_addr == {RESET_CAUSE_IDX, 2'b00});
   assign sel_wd = (reg_addr == {WDOG_CTRL_IDX, 2'b00});
   assign sel_stat = (reg_addr == {IRQ_STATUS_IDX, 2'b00});
   assign sel_mask = (reg_addr == {IRQ_MASK_IDX, 2'b00});
   assign run = (state_r == ST_RUN);
   // Cause and watchdog writes are dropped while the core itself is held in reset; mask writes are not.
   assign wr_cause = reg_wr && sel_cause && run;
   assign wr_wd = reg_wr && sel_wd && run;

   // ------------------------------------------------------------------
   // Reset sources
   // ------------------------------------------------------------------
   assign por_trig = !sup_s && mon_s && por_sel_r;
   assign por_force = wr_cause && reg_wdata[PIN_BIT];
   assign pin_trig = !pin_s;
   assign sw_trig = wr_cause && reg_wdata[SW_BIT];
   assign mcd_trig = mcd_en_r && (mcd_cnt_r == MCD_LAST);
   assign cnv_trig = cnv_en_r && !cnv_s;
   assign cmp_trig = cmp_en_r && !cmp_s;

   // ------------------------------------------------------------------
   // Watchdog
   // ------------------------------------------------------------------
   watchdog_timer u_wdt (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .ce(ce),
      .clear(!run),
      .wr(wr_wd),
      .wdata(reg_wdata),
      .active(wd_active),
      .interval(wd_intvl),
      .timeout(wd_timeout),
      .events(wd_events)
   );

   // ------------------------------------------------------------------
   // Reset sequencer
   // ------------------------------------------------------------------
   // A supply drop wins over everything; the rest are taken only in run.
   always_comb begin
      state_nxt = state_r;
      pend_nxt = pend_r;
      dly_nxt = dly_r + DLY_W'(1);
      if (por_trig) begin
         state_nxt = ST_POR;
         pend_nxt = cause_t'(CAUSE_POR_ONLY);
         dly_nxt = '0;
      end else begin
         unique case (state_r)
            ST_RUN: begin
               dly_nxt = '0;
               pend_nxt = '0;
               if (por_force) begin
                  state_nxt = ST_POR;
                  pend_nxt.por = 1'b1;
               end else if (pin_trig) begin
                  state_nxt = ST_PIN;
                  pend_nxt.pin = 1'b1;
               end else if (sw_trig) begin
                  state_nxt = ST_STRETCH;
                  pend_nxt.sw = 1'b1;
               end else if (wd_timeout) begin
                  state_nxt = ST_STRETCH;
                  pend_nxt.wdt = 1'b1;
               end else if (mcd_trig) begin
                  state_nxt = ST_STRETCH;
                  pend_nxt.missing_clock_detector = 1'b1;
               end else if (cnv_trig) begin
                  state_nxt = ST_STRETCH;
                  pend_nxt.cnv = 1'b1;
               end else if (cmp_trig) begin
                  state_nxt = ST_STRETCH;
                  pend_nxt.cmp = 1'b1;
               end else begin
                  pend_nxt = pend_r;
               end
            end
            ST_POR: begin
               if (dly_r == POR_LAST) begin
                  state_nxt = ST_PIN;
                  dly_nxt = '0;
               end
            end
            ST_PIN: begin
               dly_nxt = '0;
               if (pin_s) begin
                  state_nxt = ST_STRETCH;
               end
            end
            ST_STRETCH: begin
               if (!pin_s) begin
                  state_nxt = ST_PIN;
                  dly_nxt = '0;
               end else if (dly_r == STRETCH_LAST) begin
                  state_nxt = ST_RUN;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_r <= ST_POR;
         pend_r <= cause_t'(CAUSE_POR_ONLY);
         dly_r <= '0;
         cause_r <= cause_t'(RESET_CAUSE_RST);
         rst_pin_oe_r <= 1'b1;
         sys_rst_n_r <= 1'b0;
      end else if (ce) begin
         state_r <= state_nxt;
         pend_r <= pend_nxt;
         dly_r <= dly_nxt;
         if (state_r != ST_RUN && state_nxt == ST_RUN) begin
            cause_r <= pend_r;
         end
         rst_pin_oe_r <= (state_nxt == ST_POR);
         sys_rst_n_r <= (state_nxt == ST_RUN);
      end
   end

   // ------------------------------------------------------------------
   // Source enables and missing clock detector
   // ------------------------------------------------------------------
   // The detector watches activity from the core clock tree; clk_sys is
   // the free-running reference, so a stopped core clock still resets.
   always_ff @(posedge clk_sys) begin
      if (!rst_n || !run) begin
         cnv_en_r <= 1'b0;
         cmp_en_r <= 1'b0;
         mcd_en_r <= 1'b0;
         por_sel_r <= 1'b1;
         mcd_cnt_r <= '0;
         act_q_r <= 1'b1;
      end else if (ce) begin
         act_q_r <= act_s;
         if (act_s != act_q_r || mcd_cnt_r == MCD_LAST) begin
            mcd_cnt_r <= '0;
         end else begin
            mcd_cnt_r <= mcd_cnt_r + DLY_W'(1);
         end
         if (wr_cause) begin
            cnv_en_r <= reg_wdata[CNV_BIT];
            cmp_en_r <= reg_wdata[CMP_BIT];
            mcd_en_r <= reg_wdata[MCD_BIT];
            if (mon_s) begin
               por_sel_r <= reg_wdata[POR_BIT];
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Interrupt status, read data and outputs
   // ------------------------------------------------------------------
   // A new event in the cycle of the clearing read survives it.
   assign stat_nxt = ((reg_rd && sel_stat) ? '0 : stat_r) | wd_events;
   assign rd_val = sel_cause ? {1'b0, cause_r} :
                   sel_wd ? {3'h0, wd_active, 1'b0, wd_intvl} :
                   sel_stat ? {5'h00, stat_r} :
                   sel_mask ? {5'h00, mask_r} :
                   8'h00;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         stat_r <= '0;
         mask_r <= '0;
         irq_r <= 1'b0;
         rdata_r <= 8'h00;
      end else if (ce) begin
         stat_r <= stat_nxt;
         if (reg_wr && sel_mask) begin
            mask_r <= reg_wdata[IRQ_W-1:0];
         end
         irq_r <= |(stat_nxt & mask_r);
         rdata_r <= reg_rd ? rd_val : 8'h00;
      end
   end

   assign reg_rdata = rdata_r;
   assign irq = irq_r;
   assign reset_pin_out = 1'b0;
   assign reset_pin_oe = rst_pin_oe_r;
   assign sys_rst_n_out = sys_rst_n_r;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   property p_status_read;
      @(posedge clk_sys) disable iff (!rst_n || !ce)
      reg_rd && sel_wd |=> reg_rdata[WD_STATUS_BIT] == $past(wd_active);
   endproperty
   a_status_read: assert property (p_status_read)
      else $error("Watchdog status bit does not show the running state.");
   property p_sw_reset;
      @(posedge clk_sys) disable iff (!rst_n || !ce)
      sw_trig && !por_trig && !por_force && pin_s
      |=> !sys_rst_n_out && !reset_pin_oe && pend_r.sw;
   endproperty
   a_sw_reset: assert property (p_sw_reset)
      else $error("Software reset did not reset internally with pin idle.");
   property p_pin_force;
      @(posedge clk_sys) disable iff (!rst_n || !ce)
      por_force |=> reset_pin_oe && !sys_rst_n_out && pend_r.por;
   endproperty
   a_pin_force: assert property (p_pin_force)
      else $error("Forced power-on reset did not drive the reset pin.");
   property p_stretch;
      @(posedge clk_sys) disable iff (!rst_n || !ce)
      $rose(sys_rst_n_out) |-> $past(state_r == ST_STRETCH, 12);
   endproperty
   a_stretch: assert property (p_stretch)
      else $error("Reset left before twelve stretch cycles.");
   property p_cause_stable;
      @(posedge clk_sys) disable iff (!rst_n || !ce)
      run ##1 run |-> $stable(cause_r);
   endproperty
   a_cause_stable: assert property (p_cause_stable)
      else $error("Reset cause changed while running.");
   property p_por_only;
      @(posedge clk_sys) disable iff (!rst_n || !ce)
      $rose(sys_rst_n_out) && cause_r.por |-> cause_r == cause_t'(CAUSE_POR_ONLY);
   endproperty
   a_por_only: assert property (p_por_only)
      else $error("Power-on cause mixed with other flags.");
   property p_wdt_reset;
      @(posedge clk_sys) disable iff (!rst_n || !ce)
      run && wd_timeout && !por_trig && !reg_wr && pin_s
      |=> !sys_rst_n_out && pend_r.wdt;
   endproperty
   a_wdt_reset: assert property (p_wdt_reset)
      else $error("Watchdog timeout did not start a reset.");
   property p_mcd_reset;
      @(posedge clk_sys) disable iff (!rst_n || !ce)
      run && mcd_trig && !por_trig && !reg_wr && pin_s && !wd_timeout
      |=> !sys_rst_n_out && pend_r.missing_clock_detector;
   endproperty
   a_mcd_reset: assert property (p_mcd_reset)
      else $error("Missing clock timeout did not start a reset.");
endmodule // reset_source_and_watchdog_ctrl
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking testbench of the reset and watchdog block.
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top
   import rst_wdt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 0, rst_n = 0, ce = 1, reg_wr = 0, reg_rd = 0, cnv = 1, cmp = 1;
   logic sok = 1, ext_low = 0, act_run = 1, act = 0, pin_seen = 0, mon = 1;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, rd_v;
   logic irq, rpo, oe, srst;
   int mismatches = 0, check_count = 0, n = 0;
   // The reset pin has a pull-up; both the device and the bench pull it low.
   wire reset_pin_in = !(oe === 1'b1 || ext_low);
   always #4 clk_sys = !clk_sys;
   always @(posedge clk_sys) if (act_run) act <= !act;
   reset_source_and_watchdog_ctrl #(.POR_DELAY(20), .MCD_TIMEOUT(16)) i_dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .irq(irq), .convert_start_input(cnv), .comparator_out(cmp),
      .supply_monitor_enable_pin(mon), .supply_ok_in(sok), .reset_pin_in(reset_pin_in),
      .core_clk_activity(act), .reset_pin_out(rpo), .reset_pin_oe(oe),
      .sys_rst_n_out(srst));
   // ------------------------------------------------------------------
   // Bus and wait tasks
   // ------------------------------------------------------------------
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= {idx, 2'b00};
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] e, input string nm);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= {idx, 2'b00};
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      rd_v = reg_rdata;
      `CHK(nm, e, rd_v)
   endtask
   // Counts cycles until the core leaves reset; a hang ends the run.
   task automatic wait_run;
      n = 0;
      while (srst !== 1'b1) begin
         @(posedge clk_sys);
         n++;
         pin_seen |= (oe === 1'b1);
         if (n > 500) begin
            mismatches++;
            close_out;
         end
      end
   endtask
   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic t_boot;
      wait_run;
      `CHK("por_len", 1'b1, n >= 32)
      `CHK("pin_oe", 1'b0, oe)
      rd(RESET_CAUSE_IDX, 8'h02, "cause");
      rd(WDOG_CTRL_IDX, 8'h17, "wdctl");
      wr(8'h10, 8'hFF);
      rd(8'h10, 8'h00, "unmapped");
      rd(RESET_CAUSE_IDX, 8'h02, "cause_hold");
      $display("boot done");
   endtask
   task automatic t_wd;
      wr(IRQ_MASK_IDX, 8'h07);
      wr(WDOG_CTRL_IDX, 8'h03);
      rd(WDOG_CTRL_IDX, 8'h13, "intvl");
      wr(WDOG_CTRL_IDX, WD_DIS1_CODE);
      repeat (5) @(posedge clk_sys);
      wr(WDOG_CTRL_IDX, WD_DIS2_CODE);
      rd(WDOG_CTRL_IDX, 8'h13, "late_dis");
      wr(WDOG_CTRL_IDX, WD_DIS1_CODE);
      wr(WDOG_CTRL_IDX, WD_DIS2_CODE);
      rd(WDOG_CTRL_IDX, 8'h03, "dis");
      `CHK("irq", 1'b1, irq)
      wr(WDOG_CTRL_IDX, WD_LOCK_CODE);
      rd(WDOG_CTRL_IDX, 8'h03, "lock_off");
      wr(WDOG_CTRL_IDX, WD_ENABLE_CODE);
      wr(WDOG_CTRL_IDX, WD_DIS1_CODE);
      wr(WDOG_CTRL_IDX, WD_DIS2_CODE);
      rd(WDOG_CTRL_IDX, 8'h13, "locked");
      rd(IRQ_STATUS_IDX, 8'h07, "status");
      repeat (2) @(negedge clk_sys);
      `CHK("irq_clr", 1'b0, irq)
      wr(WDOG_CTRL_IDX, 8'h00);
      wr(WDOG_CTRL_IDX, WD_ENABLE_CODE);
      n = 0;
      while (srst === 1'b1 && n < 300) begin
         @(posedge clk_sys);
         n++;
      end
      `CHK("wd_time", 1'b1, n >= 60 && n <= 70)
      wait_run;
      rd(RESET_CAUSE_IDX, 8'h08, "wd_cause");
      rd(WDOG_CTRL_IDX, 8'h17, "wd_rst");
      wr(WDOG_CTRL_IDX, WD_DIS1_CODE);
      wr(WDOG_CTRL_IDX, WD_DIS2_CODE);
      rd(WDOG_CTRL_IDX, 8'h07, "unlocked");
      $display("watchdog done");
   endtask
   task automatic t_pin;
      @(posedge clk_sys);
      ext_low <= 1'b1;
      repeat (6) @(posedge clk_sys);
      ext_low <= 1'b0;
      wait_run;
      `CHK("stretch", 1'b1, n >= 12)
      rd(RESET_CAUSE_IDX, 8'h01, "pin_cause");
      $display("pin done");
   endtask
   // Each row: value written, trigger, expected cause, pin driven or not.
   task automatic t_src;
      logic [7:0] wv[6] = '{8'h10, 8'h01, 8'h40, 8'h20, 8'h04, 8'h02};
      int kd[6] = '{0, 0, 1, 2, 3, 4};
      logic [7:0] ex[6] = '{8'h10, 8'h02, 8'h40, 8'h20, 8'h04, 8'h02};
      logic pv[6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
      for (int i = 0; i < 6; i++) begin
         pin_seen = 0;
         wr(RESET_CAUSE_IDX, wv[i]);
         cnv <= (kd[i] != 1);
         cmp <= (kd[i] != 2);
         act_run <= (kd[i] != 3);
         sok <= (kd[i] != 4);
         n = 0;
         while (srst === 1'b1 && n < 100) begin
            @(posedge clk_sys);
            n++;
         end
         `CHK("entered", 1'b0, srst)
         {cnv, cmp, act_run, sok} <= 4'hF;
         wait_run;
         `CHK("pin_drv", pv[i], pin_seen)
         `CHK("pin_val", 1'b0, rpo)
         rd(RESET_CAUSE_IDX, ex[i], "src_cause");
      end
      $display("sources done");
   endtask
   // A deselected monitor ignores a supply drop; a deselect with the pin low is ignored.
   task automatic t_mon;
      wr(RESET_CAUSE_IDX, 8'h00);
      sok <= 1'b0;
      repeat (8) @(posedge clk_sys);
      `CHK("mon_desel", 1'b1, srst)
      sok <= 1'b1;
      repeat (3) @(posedge clk_sys);
      wr(RESET_CAUSE_IDX, 8'h02);
      mon <= 1'b0;
      repeat (3) @(posedge clk_sys);
      wr(RESET_CAUSE_IDX, 8'h00);
      mon <= 1'b1;
      repeat (3) @(posedge clk_sys);
      sok <= 1'b0;
      n = 0;
      while (srst === 1'b1 && n < 20) begin
         @(posedge clk_sys);
         n++;
      end
      `CHK("mon_gate", 1'b0, srst)
      sok <= 1'b1;
      wait_run;
      rd(RESET_CAUSE_IDX, 8'h02, "mon_cause");
      @(posedge clk_sys);
      ce <= 1'b0;
      wr(WDOG_CTRL_IDX, 8'h01);
      ce <= 1'b1;
      rd(WDOG_CTRL_IDX, 8'h17, "ce_hold");
      $display("monitor done");
   endtask
   initial begin
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_boot;
      t_wd;
      t_pin;
      t_src;
      t_mon;
      close_out;
   end
endmodule // tb_top
`default_nettype wire
